// ===== common/pcr_defs.vh
// Purpose: constants for the loop-one output configuration register bank
// Assumes: register indices; byte address on the bus is four times the index
// Notes:   definitions only

`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

// ---------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define PCR_IDX_STATE_SEL      6'h15
`define PCR_IDX_SPREAD_DIV2    6'h16
`define PCR_IDX_DIV3           6'h17
`define PCR_IDX_W0_B0          6'h18
`define PCR_IDX_W0_B1          6'h19
`define PCR_IDX_W0_B2          6'h1a
`define PCR_IDX_W0_B3          6'h1b
`define PCR_IDX_W1_B0          6'h1c
`define PCR_IDX_W1_B1          6'h1d
`define PCR_IDX_W1_B2          6'h1e
`define PCR_IDX_W1_B3          6'h1f
`define PCR_IDX_STATUS         6'h3e
`define PCR_IDX_FIRST          6'h15
`define PCR_NUM_REGS           11

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PCR_RST_STATE_SEL      8'h02
`define PCR_RST_SPREAD_DIV2    8'h01
`define PCR_RST_DIV3           8'h01
`define PCR_RST_WORD_B0        8'h00
`define PCR_RST_WORD_B1        8'h40
`define PCR_RST_WORD_B2        8'h02
`define PCR_RST_WORD_B3        8'h08

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PCR_SPREAD_BIT         7
`define PCR_DIV_MSB            6
`define PCR_DIV3_RSVD_MASK     8'h7f
`define PCR_N_HI_MSB           7
`define PCR_N_LO_MSB           7
`define PCR_N_LO_LSB           4
`define PCR_R_HI_MSB           3
`define PCR_R_LO_MSB           7
`define PCR_R_LO_LSB           3
`define PCR_Q_HI_MSB           2
`define PCR_Q_LO_MSB           7
`define PCR_Q_LO_LSB           5
`define PCR_P_MSB              4
`define PCR_P_LSB              2
`define PCR_RANGE_MSB          1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PCR_SYNC_STAGES        2

`endif

// ===== verilog/pcr_sync.v
// Purpose: two-stage synchroniser for the setting select pins
// Assumes: pins are asynchronous to clk_sys
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module pcr_sync #(
	parameter WIDTH = 3
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             rst,
	// asynchronous in, synchronous out
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] stable_q;

	// one chain per bit
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1)
		begin : g_bit
			always @(posedge clk_sys)
			begin
				if (rst)
				begin
					meta_q[gi]   <= 1'b0;
					stable_q[gi] <= 1'b0;
				end
				else
				begin
					meta_q[gi]   <= asyncIn[gi];
					stable_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign syncOut = stable_q;

endmodule // pcr_sync

// ===== verilog/pcr_regs.v
// Purpose: APB register bank for loop-one output and multiplier settings
// Assumes: APB with zero wait states; sync reset; 50 MHz clk_sys
// Notes:   eleven byte-wide registers plus one read-only status word
//
// Contract
// [R1] bit 7 at 0x16 picks spread type: 0 down, 1 center; resets 0
// [R2] 0x16[6:0] is output-two divider; 0 means reset/standby; resets 1
// [R3] 0x17[6:0] is output-three divider; 0 means reset/standby; resets 1
// [R4] software writes only zero to reserved bit 7 at 0x17; resets 0
// [R5] 0x18..0x1B hold word zero split into N, R, Q and P fields
// [R6] 0x1C..0x1F hold word one, same split, defaults N=4 R=0 Q=16 P=2
// [R7] 0x1B[1:0] selects oscillator range of word zero; resets 00
// [R8] 0x1F[1:0] selects oscillator range of word one; resets 00
// [R9] each state select bit picks state zero or one; only bit 1 resets 1
// [R10] three select pins index which per-setting bit applies
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "pcr_defs.vh"

module pcr_regs (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// setting select pins
	input  wire        settingSelectPin0,
	input  wire        settingSelectPin1,
	input  wire        settingSelectPin2,
	// output stage controls
	output wire [7:0]  out23StateSelect,
	output reg         out23StateSelectBit,
	output wire        loop1SpreadType,
	output wire [6:0]  out2Divider,
	output wire [6:0]  out3Divider,
	output reg         out2Standby,
	output reg         out3Standby,
	// multiplier/divider word zero
	output wire [11:0] loop1Word0NField,
	output wire [8:0]  loop1Word0RField,
	output wire [5:0]  loop1Word0QField,
	output wire [2:0]  loop1Word0PField,
	output wire [1:0]  loop1Word0OscRange,
	// multiplier/divider word one
	output wire [11:0] loop1Word1NField,
	output wire [8:0]  loop1Word1RField,
	output wire [5:0]  loop1Word1QField,
	output wire [2:0]  loop1Word1PField,
	output wire [1:0]  loop1Word1OscRange,
	// active setting index
	output wire [2:0]  activeSetting
);

	// ---------------------------------------------------------------
	// storage helpers
	// ---------------------------------------------------------------

	// reset value per register slot
	function [7:0] resetVal;
		input [3:0] slot;
		begin
			case (slot)
				4'h0: resetVal = `PCR_RST_STATE_SEL;   // [R9]
				4'h1: resetVal = `PCR_RST_SPREAD_DIV2; // [R1] [R2]
				4'h2: resetVal = `PCR_RST_DIV3;        // [R3] [R4]
				4'h3: resetVal = `PCR_RST_WORD_B0;     // [R5]
				4'h4: resetVal = `PCR_RST_WORD_B1;
				4'h5: resetVal = `PCR_RST_WORD_B2;
				4'h6: resetVal = `PCR_RST_WORD_B3;     // [R7]
				4'h7: resetVal = `PCR_RST_WORD_B0;     // [R6]
				4'h8: resetVal = `PCR_RST_WORD_B1;
				4'h9: resetVal = `PCR_RST_WORD_B2;
				4'ha: resetVal = `PCR_RST_WORD_B3;     // [R8]
				default: resetVal = 8'h00;
			endcase
		end
	endfunction

	// writable bits per slot; the reserved divider bit never stores a one
	function [7:0] writeMask;
		input [3:0] slot;
		begin
			case (slot)
				4'h2: writeMask = `PCR_DIV3_RSVD_MASK; // [R4]
				default: writeMask = 8'hff;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire [5:0] regIndex;
	wire       wordAligned;
	wire [5:0] slotFull;
	wire [3:0] slot;
	wire       inBank;
	wire       isStatus;
	wire       mapped;
	wire       setupPhase;
	wire       accessPhase;
	wire       writeLow;

	assign regIndex    = paddr[7:2];
	assign wordAligned = (paddr[1:0] == 2'h0);
	assign slotFull    = regIndex - `PCR_IDX_FIRST;
	assign slot        = slotFull[3:0];
	assign inBank      = (regIndex >= `PCR_IDX_FIRST) && (regIndex <= `PCR_IDX_W1_B3);
	assign isStatus    = (regIndex == `PCR_IDX_STATUS);
	assign mapped      = wordAligned && (inBank || isStatus);
	assign setupPhase  = psel && !penable;
	assign accessPhase = psel && penable;
	// status is read-only, and only lane zero carries register data
	assign writeLow    = accessPhase && pwrite && pstrb[0] && wordAligned && inBank;

	// zero wait states: read data and error are staged in the setup cycle
	assign pready = 1'b1;

	// ---------------------------------------------------------------
	// register bank
	// ---------------------------------------------------------------
	reg [8*`PCR_NUM_REGS-1:0] bank_q;

	// one byte register per slot, each with its own reset and mask
	genvar gi;
	generate
		for (gi = 0; gi < `PCR_NUM_REGS; gi = gi + 1)
		begin : g_reg
			wire [7:0] mask;
			wire [7:0] wrVal;
			assign mask  = writeMask(gi[3:0]);
			assign wrVal = pwdata[7:0] & mask;
			always @(posedge clk_sys)
			begin
				if (rst)
					bank_q[8*gi+7:8*gi] <= resetVal(gi[3:0]);
				else if (writeLow && (slot == gi[3:0]))
					bank_q[8*gi+7:8*gi] <= wrVal;
			end
		end
	endgenerate

	// byte views
	wire [7:0] regStateSel;
	wire [7:0] regSpreadDiv2;
	wire [7:0] regDiv3;
	wire [7:0] w0b0;
	wire [7:0] w0b1;
	wire [7:0] w0b2;
	wire [7:0] w0b3;
	wire [7:0] w1b0;
	wire [7:0] w1b1;
	wire [7:0] w1b2;
	wire [7:0] w1b3;

	assign regStateSel   = bank_q[7:0];
	assign regSpreadDiv2 = bank_q[15:8];
	assign regDiv3       = bank_q[23:16];
	assign w0b0          = bank_q[31:24];
	assign w0b1          = bank_q[39:32];
	assign w0b2          = bank_q[47:40];
	assign w0b3          = bank_q[55:48];
	assign w1b0          = bank_q[63:56];
	assign w1b1          = bank_q[71:64];
	assign w1b2          = bank_q[79:72];
	assign w1b3          = bank_q[87:80];

	// ---------------------------------------------------------------
	// field unpacking
	// ---------------------------------------------------------------

	// divider and spread fields
	assign loop1SpreadType = regSpreadDiv2[`PCR_SPREAD_BIT];  // [R1]
	assign out2Divider     = regSpreadDiv2[`PCR_DIV_MSB:0];   // [R2]
	assign out3Divider     = regDiv3[`PCR_DIV_MSB:0];         // [R3]
	assign out23StateSelect = regStateSel;

	// word zero: fields straddle byte boundaries, msb byte first
	assign loop1Word0NField = {w0b0[`PCR_N_HI_MSB:0],
		w0b1[`PCR_N_LO_MSB:`PCR_N_LO_LSB]};                   // [R5]
	assign loop1Word0RField = {w0b1[`PCR_R_HI_MSB:0],
		w0b2[`PCR_R_LO_MSB:`PCR_R_LO_LSB]};                   // [R5]
	assign loop1Word0QField = {w0b2[`PCR_Q_HI_MSB:0],
		w0b3[`PCR_Q_LO_MSB:`PCR_Q_LO_LSB]};                   // [R5]
	assign loop1Word0PField = w0b3[`PCR_P_MSB:`PCR_P_LSB];    // [R5]
	assign loop1Word0OscRange = w0b3[`PCR_RANGE_MSB:0];       // [R7]

	// word one: identical split
	assign loop1Word1NField = {w1b0[`PCR_N_HI_MSB:0],
		w1b1[`PCR_N_LO_MSB:`PCR_N_LO_LSB]};                   // [R6]
	assign loop1Word1RField = {w1b1[`PCR_R_HI_MSB:0],
		w1b2[`PCR_R_LO_MSB:`PCR_R_LO_LSB]};                   // [R6]
	assign loop1Word1QField = {w1b2[`PCR_Q_HI_MSB:0],
		w1b3[`PCR_Q_LO_MSB:`PCR_Q_LO_LSB]};                   // [R6]
	assign loop1Word1PField = w1b3[`PCR_P_MSB:`PCR_P_LSB];    // [R6]
	assign loop1Word1OscRange = w1b3[`PCR_RANGE_MSB:0];       // [R8]

	// ---------------------------------------------------------------
	// setting select pins
	// ---------------------------------------------------------------
	wire [2:0] pinsRaw;
	wire [2:0] pinsSync;

	assign pinsRaw = {settingSelectPin2, settingSelectPin1, settingSelectPin0};

	// pins are asynchronous; two flops before any decode
	pcr_sync #(
		.WIDTH   (3)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.asyncIn (pinsRaw),
		.syncOut (pinsSync)
	);

	assign activeSetting = pinsSync;

	// ---------------------------------------------------------------
	// active state and standby flags
	// ---------------------------------------------------------------

	// registered so downstream sees glitch-free levels; one cycle behind a write
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			out23StateSelectBit <= 1'b0;
			out2Standby         <= 1'b0;
			out3Standby         <= 1'b0;
		end
		else
		begin
			out23StateSelectBit <= regStateSel[pinsSync];                // [R9] [R10]
			out2Standby         <= (out2Divider == 7'h00);              // [R2]
			out3Standby         <= (out3Divider == 7'h00);              // [R3]
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	wire [7:0]  bankByte;
	wire [31:0] statusWord;
	reg  [31:0] readMux;

	assign bankByte   = bank_q[8*slot +: 8];
	// live view of the block: pins, selected state, standby levels
	assign statusWord = {26'h0000000, out3Standby, out2Standby,
		out23StateSelectBit, pinsSync};                                 // [R10]

	// unmapped or misaligned addresses read zero
	always @*
	begin
		readMux = 32'h00000000;
		if (mapped && inBank)
			readMux = {24'h000000, bankByte};
		else if (mapped && isStatus)
			readMux = statusWord;
	end

	// stage data and error during setup so the access cycle needs no wait
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (setupPhase)
		begin
			prdata  <= pwrite ? 32'h00000000 : readMux;
			// writes to the read-only status word are refused too
			pslverr <= !mapped || (pwrite && isStatus);
		end
		else if (!psel)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

endmodule // pcr_regs

// ===== testbench/pcr_regs_checker.sv
// Purpose: port assertions for the loop-one config registers
// Assumes: zero-wait APB, synchronous active-high reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps

module pcr_regs_checker (
	// clock and reset
	input wire        clk_sys,
	input wire        rst,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	input wire [31:0] prdata,
	input wire        pslverr,
	// outputs under watch
	input wire [7:0]  out23StateSelect,
	input wire        out23StateSelectBit,
	input wire        loop1SpreadType,
	input wire [6:0]  out2Divider,
	input wire [6:0]  out3Divider,
	input wire        out2Standby,
	input wire        out3Standby,
	input wire [2:0]  loop1Word0PField,
	input wire [1:0]  loop1Word0OscRange,
	input wire [11:0] loop1Word1NField,
	input wire [1:0]  loop1Word1OscRange,
	input wire [2:0]  activeSetting
);
	// ----
	// helpers
	// ----
	// a write lands only when strobed and word aligned
	wire       wr = psel && penable && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
	wire [5:0] ix = paddr[7:2];
	wire       selNow = out23StateSelect[activeSetting];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ----
	// properties
	// ----
	property p_ssc; wr && ix == 6'h16 |=> loop1SpreadType == $past(pwdata[7]); endproperty
	a_ssc: assert property (p_ssc) else $error("spread type");
	property p_div2; wr && ix == 6'h16 |=> out2Divider == $past(pwdata[6:0]); endproperty
	a_div2: assert property (p_div2) else $error("div2");
	property p_div3; wr && ix == 6'h17 |=> out3Divider == $past(pwdata[6:0]); endproperty
	a_div3: assert property (p_div3) else $error("div3");
	property p_rsv; psel && penable && !pwrite && paddr == 8'h5c |-> !prdata[7]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit");
	// standby trails the divider by one edge
	property p_stby; 1 |=> out2Standby == ($past(out2Divider) == 7'h00)
		&& out3Standby == ($past(out3Divider) == 7'h00); endproperty
	a_stby: assert property (p_stby) else $error("standby");
	property p_w0; wr && ix == 6'h1b |=> loop1Word0PField == $past(pwdata[4:2])
		&& loop1Word0OscRange == $past(pwdata[1:0]); endproperty
	a_w0: assert property (p_w0) else $error("word0");
	property p_w1n; wr && ix == 6'h1c |=> loop1Word1NField[11:4] == $past(pwdata[7:0]);
	endproperty
	a_w1n: assert property (p_w1n) else $error("word1 n");
	property p_w1r; wr && ix == 6'h1f |=> loop1Word1OscRange == $past(pwdata[1:0]); endproperty
	a_w1r: assert property (p_w1r) else $error("word1 range");
	property p_sel; 1 |=> out23StateSelectBit == $past(selNow); endproperty
	a_sel: assert property (p_sel) else $error("state bit");

	// main scenarios reached
	c_zero: cover property (wr && ix == 6'h16 && pwdata[6:0] == 7'h00);
	c_err: cover property (pslverr);
	c_sel: cover property ($rose(out23StateSelectBit));
endmodule // pcr_regs_checker

bind pcr_regs pcr_regs_checker u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pslverr(pslverr), .out23StateSelect(out23StateSelect),
	.out23StateSelectBit(out23StateSelectBit), .loop1SpreadType(loop1SpreadType),
	.out2Divider(out2Divider), .out3Divider(out3Divider), .out2Standby(out2Standby),
	.out3Standby(out3Standby), .loop1Word0PField(loop1Word0PField),
	.loop1Word0OscRange(loop1Word0OscRange), .loop1Word1NField(loop1Word1NField),
	.loop1Word1OscRange(loop1Word1OscRange), .activeSetting(activeSetting));

// ===== testbench/tb.sv
// Purpose: self-checking bench for the loop-one config registers
// Assumes: zero-wait APB; byte address is four times the index
// Notes: reads queue their expectation; a monitor compares
`timescale 1ns/1ps

`define CHK(n, e, a) \
	checks++; \
	if ((a) !== (e)) \
	begin \
		errTotal++; \
		$display("mismatch %s exp %h got %h", n, e, a); \
	end

module tb;
	logic        clk_sys = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [3:0]  pstrb = 4'hf;
	logic [3:0]  st = 4'hf;
	logic [2:0]  pins = 0;
	logic [31:0] seed = 5;
	logic [31:0] rw;
	logic [32:0] ex;
	logic [32:0] expQ[$];
	logic [7:0]  v[0:10];
	logic [7:0]  rv[0:10];
	int          checks = 0;
	int          errTotal = 0;
	int          cyc = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, selBit, spread, stby2, stby3;
	wire  [7:0]  stateSel;
	wire  [6:0]  div2, div3;
	wire  [11:0] w0n, w1n;
	wire  [8:0]  w0r, w1r;
	wire  [5:0]  w0q, w1q;
	wire  [2:0]  w0p, w1p, act;
	wire  [1:0]  w0o, w1o;

	pcr_regs DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .settingSelectPin0(pins[0]),
		.settingSelectPin1(pins[1]), .settingSelectPin2(pins[2]),
		.out23StateSelect(stateSel), .out23StateSelectBit(selBit),
		.loop1SpreadType(spread), .out2Divider(div2), .out3Divider(div3),
		.out2Standby(stby2), .out3Standby(stby3), .loop1Word0NField(w0n),
		.loop1Word0RField(w0r), .loop1Word0QField(w0q), .loop1Word0PField(w0p),
		.loop1Word0OscRange(w0o), .loop1Word1NField(w1n), .loop1Word1RField(w1r),
		.loop1Word1QField(w1q), .loop1Word1PField(w1p), .loop1Word1OscRange(w1o),
		.activeSetting(act));

	always #10 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// one apb transfer; every transfer leaves its expectation for the monitor
	// writes expect zero read data, since the slave stages nothing for them
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		expQ.push_back(e);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= st;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask

	task testDone;
		$display("checks %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// read data is taken at the access edge, before it is cleared
	always @(posedge clk_sys)
	begin
		if (psel && penable && pready && expQ.size() > 0)
		begin
			ex = expQ.pop_front();
			`CHK("prdata", ex[31:0], prdata)
			`CHK("pslverr", ex[32], pslverr)
		end
	end

	// a hang counts against the run
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errTotal++;
			testDone;
		end
	end

	initial
	begin
		rv = '{8'h02, 8'h01, 8'h01, 8'h00, 8'h40, 8'h02, 8'h08, 8'h00, 8'h40, 8'h02, 8'h08};
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		for (int i = 0; i < 11; i++)
			xfer(0, 8'h54 + 8'(4 * i), 0, {25'h0, rv[i]});
		$display("test reset done");
		// random contents; reserved bit kept clear by software
		for (int i = 0; i < 11; i++)
		begin
			rw = rnd();
			v[i] = (i == 2) ? rw[7:0] & 8'h7f : rw[7:0];
			xfer(1, 8'h54 + 8'(4 * i), {rw[31:8], v[i]}, 0);
		end
		for (int i = 0; i < 11; i++)
			xfer(0, 8'h54 + 8'(4 * i), 0, {25'h0, v[i]});
		@(negedge clk_sys);
		`CHK("word0", {v[3], v[4], v[5], v[6]}, {w0n, w0r, w0q, w0p, w0o})
		`CHK("word1", {v[7], v[8], v[9], v[10]}, {w1n, w1r, w1q, w1p, w1o})
		`CHK("div2", v[1], {spread, div2})
		`CHK("div3", v[2][6:0], div3)
		`CHK("statesel", v[0], stateSel)
		@(posedge clk_sys);
		$display("test readback done");
		xfer(1, 8'h58, 32'h80, 0);
		xfer(1, 8'h5c, 32'h00, 0);
		@(negedge clk_sys);
		`CHK("standby", 3'h7, {spread, stby2, stby3})
		@(posedge clk_sys);
		xfer(1, 8'h58, 32'h05, 0);
		xfer(1, 8'h5c, 32'h7f, 0);
		@(negedge clk_sys);
		`CHK("active", 2'h0, {stby2, stby3})
		@(posedge clk_sys);
		$display("test standby done");
		for (int s = 0; s < 8; s++)
		begin
			pins <= 3'(s);
			repeat (4) @(posedge clk_sys);
			@(negedge clk_sys);
			`CHK("setting", 3'(s), act)
			`CHK("statebit", v[0][s], selBit)
			@(posedge clk_sys);
		end
		$display("test pins done");
		// status shows pins 7, the picked state bit and both dividers running
		xfer(0, 8'hf8, 0, {27'h0, 2'h0, v[0][7], 3'h7});
		// refused and ignored accesses leave the bank alone
		xfer(1, 8'hf8, 32'hff, {1'b1, 32'h0});
		xfer(0, 8'h00, 0, {1'b1, 32'h0});
		xfer(0, 8'h59, 0, {1'b1, 32'h0});
		st = 4'h0;
		xfer(1, 8'h58, 32'h33, 0);
		st = 4'hf;
		xfer(0, 8'h58, 0, 33'h05);
		$display("test refusal done");
		testDone;
	end
endmodule // tb
